// ### swx_core.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - immediate opcode computes immediate minus w
// - immediate form always writes w
// - file opcode computes file minus w
// - dest bit 0 to w, 1 to file
// - access bit 0 uses access bank
// - access bit 1 uses bank select register
// - immediate form: one word, four quarter-phases
// - file form: one word, four quarter-phases
// - update n, ov, c, dc, z only
// - carry is inverted borrow
// - n is bit 7, z all zero
module swx_core (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // instruction from fetch unit
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_WORD_I,
    output logic INSTR_READY_O,
    output logic INSTR_DONE_O,
    // banked data memory
    output swx_pkg::swx_mem_req_t MEM_O,
    input wire logic [7:0] MEM_RDATA_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output swx_pkg::swx_apb_rsp_t APB_O,
    // observation of core state
    output logic [7:0] W_O,
    output logic [4:0] STATUS_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    // all registered state in one bundle; keeping it in one struct means
    // the reset list below and the next-state copy cannot drift apart
    // unnoticed, at the price of one wide register
    typedef struct packed {
        swx_pkg::swx_phase_t phase; // quarter-phase
        logic is_file;              // file form in flight
        logic dest_file;            // result goes back to file
        logic [11:0] addr;          // resolved file address
        logic [7:0] opa;            // minuend latched at decode
        logic [7:0] res;            // difference from process phase
        logic [4:0] flg;            // flags from process phase
        logic [7:0] w;              // working register
        logic [4:0] status;         // arithmetic flags
        logic [3:0] bank_select_reg;            // bank_select_reg
        logic [7:0] last;           // last difference
        logic bad;                  // sticky unknown opcode seen
        logic [31:0] prdata;        // read data captured in setup
        logic mem_rd;               // read strobe
        logic mem_wr;               // write strobe
        logic done;                 // end-of-cycle pulse
    } swx_state_t;

    swx_state_t st_ff;  // current state
    swx_state_t nxt_st; // next state

    // subtraction results for the process phase
    // pure functions of the minuend and w; only the process phase latches
    // them, so a memory bus that changes in other phases is harmless
    logic [7:0] sub_a;   // minuend
    logic [8:0] sub_full; // 8-bit difference with no-borrow
    logic [4:0] sub_nib; // low nibble with no-borrow
    logic [4:0] sub_flags; // flags packed by field position

    // bus decode helpers
    // one decode serves both the write and the read path
    logic apb_setup;  // first cycle of a transfer
    logic apb_access; // completing cycle of a transfer
    logic [2:0] hit;  // decoded register, zero if unmapped

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // decode a byte address to a register number, 0 when unmapped
    // only whole aligned words are mapped; any other byte address,
    // including the unused bytes inside a word, counts as unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        unique case (a)
            swx_pkg::SWX_OFS_W: r = 3'h1;
            swx_pkg::SWX_OFS_STATUS: r = 3'h2;
            swx_pkg::SWX_OFS_BSR: r = 3'h3;
            swx_pkg::SWX_OFS_RESULT: r = 3'h4;
            swx_pkg::SWX_OFS_EXEC: r = 3'h5;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // resolve file address from access bit and bank select
    // result is {bank, file address}: sixteen banks of 256 bytes
    // the access bank reaches common registers with no bank set-up
    function automatic logic [11:0] resolve(
        input logic acc,
        input logic [7:0] f,
        input logic [3:0] bank
    );
        logic [11:0] r;
        r = 12'h000;
        if (!acc) begin
            // access bank: low half from bank 0, high half from top bank
            if (f[7]) begin
                r = {swx_pkg::SWX_ACC_HI_BANK, f};
            end else begin
                r = {swx_pkg::SWX_ACC_LO_BANK, f};
            end
        end else begin
            r = {bank, f};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // arithmetic

    // minuend is the immediate or the file value read in phase two
    // memory data is used straight from the pins: it is only valid in the
    // process phase, which is the only phase that latches the difference
    always_comb begin
        if (st_ff.is_file) begin
            sub_a = MEM_RDATA_I;
        end else begin
            sub_a = st_ff.opa;
        end
    end

    // two's complement: a + ~w + 1, top bit is no-borrow
    // the carry out is therefore the inverted borrow with no extra logic
    // the low nibble is summed apart to get the nibble no-borrow
    assign sub_full = {1'b0, sub_a} + {1'b0, ~st_ff.w} + 9'h001;
    assign sub_nib = {1'b0, sub_a[3:0]} + {1'b0, ~st_ff.w[3:0]} + 5'h01;

    // flags from the difference
    // packed by field position so the whole status word is written at once
    always_comb begin
        sub_flags = 5'h00;
        sub_flags[swx_pkg::SWX_ST_C] = sub_full[8];
        sub_flags[swx_pkg::SWX_ST_DC] = sub_nib[4];
        sub_flags[swx_pkg::SWX_ST_Z] = (sub_full[7:0] == 8'h00);
        // signed overflow: operand signs differ and result sign flips
        sub_flags[swx_pkg::SWX_ST_OV] = (sub_a[7] != st_ff.w[7])
            && (sub_full[7] != sub_a[7]);
        sub_flags[swx_pkg::SWX_ST_N] = sub_full[7];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // the slave never waits: data is captured in setup, done in access
    // a master that skipped the setup cycle would read stale data; that is
    // outside the bus protocol, so no guard is spent on it
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_access = PSEL_I && PENABLE_I;
    assign hit = reg_sel(PADDR_I);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    // sequencer, bus writes and bus read capture
    // strobes default low so each one lasts exactly one cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_st.mem_rd = 1'b0;
        nxt_st.mem_wr = 1'b0;
        nxt_st.done = 1'b0;

        // software writes land first so the core's update wins below
        if (apb_access && PWRITE_I) begin
            unique case (hit)
                // working register
                3'h1: begin
                    nxt_st.w = PWDATA_I[7:0];
                end
                // status flags
                3'h2: begin
                    nxt_st.status = PWDATA_I[4:0];
                end
                // bank_select_reg, used by the next file form decoded
                3'h3: begin
                    nxt_st.bank_select_reg = PWDATA_I[3:0];
                end
                3'h5: begin
                    // write one to clear the sticky unknown-opcode bit
                    if (PWDATA_I[0]) begin
                        nxt_st.bad = 1'b0;
                    end
                end
                default: begin
                    // read-only or unmapped: no effect
                end
            endcase
        end

        // quarter-phase sequencer, one cycle per phase; decode holds until a known opcode is offered
        unique case (st_ff.phase)
            swx_pkg::SWX_Q1: begin
                // decode: take a word when offered
                // the opcode is checked here once; later phases only use the
                // latched form, so the word may change right after decode
                if (INSTR_VALID_I) begin
                    if (INSTR_WORD_I[15:8] == swx_pkg::SWX_OP_IMM) begin
                        nxt_st.is_file = 1'b0;
                        nxt_st.dest_file = 1'b0;
                        nxt_st.opa = INSTR_WORD_I[7:0];
                        nxt_st.phase = swx_pkg::SWX_Q2;
                    end else if (INSTR_WORD_I[15:10] == swx_pkg::SWX_OP_FILE) begin
                        nxt_st.is_file = 1'b1;
                        nxt_st.dest_file = INSTR_WORD_I[swx_pkg::SWX_DEST_BIT];
                        // bank taken at decode, so a late bank write cannot tear it
                        nxt_st.addr = resolve(INSTR_WORD_I[swx_pkg::SWX_ACC_BIT],
                            INSTR_WORD_I[7:0], st_ff.bank_select_reg);
                        nxt_st.mem_rd = 1'b1;
                        nxt_st.phase = swx_pkg::SWX_Q2;
                    end else begin
                        // not ours: refuse and flag it, stay in decode
                        nxt_st.bad = 1'b1;
                    end
                end
            end
            swx_pkg::SWX_Q2: begin
                // read phase: memory answers on the next edge
                // the immediate form has nothing to fetch and just waits
                nxt_st.phase = swx_pkg::SWX_Q3;
            end
            swx_pkg::SWX_Q3: begin
                // process: latch difference and flags
                // write strobe raised here so it lines up with phase four
                nxt_st.res = sub_full[7:0];
                nxt_st.flg = sub_flags;
                nxt_st.mem_wr = st_ff.is_file && st_ff.dest_file;
                nxt_st.phase = swx_pkg::SWX_Q4;
            end
            swx_pkg::SWX_Q4: begin
                // write destination and flags
                // w is left alone when the result goes back to the file
                if (!(st_ff.is_file && st_ff.dest_file)) begin
                    nxt_st.w = st_ff.res;
                end
                nxt_st.status = st_ff.flg;
                nxt_st.last = st_ff.res;
                nxt_st.done = 1'b1;
                nxt_st.phase = swx_pkg::SWX_Q1;
            end
        endcase

        // read data is captured in setup so the answer comes from flops
        // upper bits of every word read as zero
        if (apb_setup && !PWRITE_I) begin
            unique case (hit)
                // working register
                3'h1: begin
                    nxt_st.prdata = {24'h000000, st_ff.w};
                end
                // status flags
                3'h2: begin
                    nxt_st.prdata = {27'h0000000, st_ff.status};
                end
                // bank_select_reg
                3'h3: begin
                    nxt_st.prdata = {28'h0000000, st_ff.bank_select_reg};
                end
                // last difference, kept for software after the cycle ends
                3'h4: begin
                    nxt_st.prdata = {24'h000000, st_ff.last};
                end
                3'h5: begin
                    // bit 0 sticky unknown opcode, bit 1 busy
                    nxt_st.prdata = {30'h00000000,
                        (st_ff.phase != swx_pkg::SWX_Q1), st_ff.bad};
                end
                default: begin
                    nxt_st.prdata = 32'h00000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // single state register, constants only under reset
    // every field is listed so none can keep an unknown after reset
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            // sequencer back to decode
            st_ff.phase <= swx_pkg::SWX_Q1;
            st_ff.is_file <= 1'b0;
            st_ff.dest_file <= 1'b0;
            st_ff.addr <= 12'h000;
            st_ff.opa <= 8'h00;
            st_ff.res <= 8'h00;
            st_ff.flg <= 5'h00;
            // software-visible registers
            st_ff.w <= swx_pkg::SWX_RST_W;
            st_ff.status <= swx_pkg::SWX_RST_STATUS;
            st_ff.bank_select_reg <= swx_pkg::SWX_RST_BSR;
            st_ff.last <= 8'h00;
            st_ff.bad <= 1'b0;
            // bus answer and strobes quiet
            st_ff.prdata <= 32'h00000000;
            st_ff.mem_rd <= 1'b0;
            st_ff.mem_wr <= 1'b0;
            st_ff.done <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // ready is combinational from the phase, done comes straight from a flop
    // ready depends on a flop only, so it cannot loop back through the fetcher
    assign INSTR_READY_O = (st_ff.phase == swx_pkg::SWX_Q1);
    assign INSTR_DONE_O = st_ff.done;

    // memory request straight from flops
    // address holds from the read strobe until the next file form
    assign MEM_O.rd = st_ff.mem_rd;
    assign MEM_O.wr = st_ff.mem_wr;
    assign MEM_O.addr = st_ff.addr;
    assign MEM_O.wdata = st_ff.res;

    // zero-wait answer, error on unmapped address
    // a write to a read-only register is ignored without an error
    assign APB_O.prdata = st_ff.prdata;
    assign APB_O.pready = apb_access;
    assign APB_O.pslverr = apb_access && (hit == 3'h0);

    // observation
    // w and status as the next instruction will see them
    assign W_O = st_ff.w;
    assign STATUS_O = st_ff.status;

endmodule

// ### swx_pkg.sv
package swx_pkg;

    // quarter-phases of one instruction cycle, gray along the loop
    typedef enum logic [1:0] {
        SWX_Q1 = 2'b00, // decode
        SWX_Q2 = 2'b01, // operand read
        SWX_Q3 = 2'b11, // process
        SWX_Q4 = 2'b10  // write destination
    } swx_phase_t;

    // opcode match patterns
    localparam logic [7:0] SWX_OP_IMM = 8'h08;  // upper byte of sub_w_from_imm
    localparam logic [5:0] SWX_OP_FILE = 6'h17; // upper six bits of sub_w_from_file
    localparam int SWX_DEST_BIT = 9;            // destination select in the word
    localparam int SWX_ACC_BIT = 8;             // access select in the word

    // access bank split: low half in bank 0, high half in the top bank
    localparam logic [3:0] SWX_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] SWX_ACC_HI_BANK = 4'hF;

    // status field positions
    localparam int SWX_ST_C = 0;
    localparam int SWX_ST_DC = 1;
    localparam int SWX_ST_Z = 2;
    localparam int SWX_ST_OV = 3;
    localparam int SWX_ST_N = 4;
    localparam int SWX_ST_W = 5;

    // register byte offsets on the bus
    localparam logic [7:0] SWX_OFS_W = 8'h00;
    localparam logic [7:0] SWX_OFS_STATUS = 8'h04;
    localparam logic [7:0] SWX_OFS_BSR = 8'h08;
    localparam logic [7:0] SWX_OFS_RESULT = 8'h0C;
    localparam logic [7:0] SWX_OFS_EXEC = 8'h10;

    // reset values
    localparam logic [7:0] SWX_RST_W = 8'h00;
    localparam logic [4:0] SWX_RST_STATUS = 5'h00;
    localparam logic [3:0] SWX_RST_BSR = 4'h0;

    // data memory request travelling as one bundle
    typedef struct packed {
        logic rd;          // read strobe, one cycle
        logic wr;          // write strobe, one cycle
        logic [11:0] addr; // bank and file address
        logic [7:0] wdata; // write data
    } swx_mem_req_t;

    // apb response bundle
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swx_apb_rsp_t;

endpackage

// ### swx_mem_model.sv
`timescale 1ns/1ps
module swx_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // request from the core and read data back
    input wire swx_pkg::swx_mem_req_t req_i,
    output logic [7:0] rdata_o
);
    logic [7:0] m [0:4095]; // sixteen banks of 256 bytes
    // data is valid only in the cycle after a read strobe
    // otherwise it flips, so a late sample never sees stale data
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            if (req_i.wr) begin
                m[req_i.addr] <= req_i.wdata;
            end
            rdata_o <= req_i.rd ? m[req_i.addr] : ~rdata_o;
        end
    end
endmodule

// ### swx_core_assertions.sv
`timescale 1ns/1ps
module swx_core_assertions (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // instruction and memory ports
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_WORD_I,
    input wire logic INSTR_READY_O,
    input wire logic INSTR_DONE_O,
    input wire swx_pkg::swx_mem_req_t MEM_O,
    input wire logic [7:0] MEM_RDATA_I,
    // core state
    input wire logic [7:0] W_O,
    input wire logic [4:0] STATUS_O,
    // register bus, watched to follow the bank select register
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I
);
    logic tk_imm; // immediate form taken at decode
    logic tk_file; // file form taken at decode
    logic [7:0] fld; // low byte of the word
    logic [3:0] bank_ff; // bank select as last written over the bus
    assign fld = INSTR_WORD_I[7:0];
    assign tk_imm = INSTR_READY_O && INSTR_VALID_I && INSTR_WORD_I[15:8] == 8'h08;
    assign tk_file = INSTR_READY_O && INSTR_VALID_I && INSTR_WORD_I[15:10] == 6'h17;
    // follow bus writes to the bank select register
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bank_ff <= swx_pkg::SWX_RST_BSR;
        end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == swx_pkg::SWX_OFS_BSR) begin
            bank_ff <= PWDATA_I[3:0];
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    ////////////////////////////////////////////////////////////////////////
    chk_done_latency: assert property ((tk_imm || tk_file) |-> ##4 INSTR_DONE_O)
        else $error("done not four cycles after decode");
    chk_file_read: assert property (tk_file |=> MEM_O.rd ##1 !MEM_O.rd)
        else $error("file operand read strobe wrong");
    chk_imm_quiet: assert property (tk_imm |=> (!MEM_O.rd && !MEM_O.wr) [*3])
        else $error("immediate form touched memory");
    chk_dest_file: assert property (tk_file && INSTR_WORD_I[9] |-> ##3 MEM_O.wr)
        else $error("missing file write back");
    chk_dest_w: assert property (tk_file && !INSTR_WORD_I[9] |-> ##3 !MEM_O.wr)
        else $error("file written while dest is w");
    chk_access_bank: assert property (tk_file && !INSTR_WORD_I[8] |=>
        MEM_O.addr == {($past(fld) >= 8'h80) ? 4'hF : 4'h0, $past(fld)})
        else $error("access bank address wrong");
    chk_file_addr: assert property (tk_file |=> MEM_O.addr[7:0] == $past(fld)
        && (!$past(INSTR_WORD_I[8]) || MEM_O.addr[11:8] == $past(bank_ff)))
        else $error("file address wrong");
    chk_wdata_diff: assert property (MEM_O.wr |->
        MEM_O.wdata == 8'($past(MEM_RDATA_I) - W_O))
        else $error("write back data is not file minus w");
    chk_imm_result: assert property (tk_imm |-> ##4
        W_O == 8'($past(fld, 4) - $past(W_O, 4))
        && STATUS_O[0] == ($past(fld, 4) >= $past(W_O, 4)))
        else $error("immediate difference or carry wrong");
    chk_nz_flags: assert property (tk_imm |-> ##4
        STATUS_O[4] == W_O[7] && STATUS_O[2] == (W_O == 8'h00))
        else $error("negative or zero flag wrong");
endmodule
bind swx_core swx_core_assertions u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .INSTR_VALID_I(INSTR_VALID_I), .INSTR_WORD_I(INSTR_WORD_I), .INSTR_READY_O(INSTR_READY_O),
    .INSTR_DONE_O(INSTR_DONE_O), .MEM_O(MEM_O), .MEM_RDATA_I(MEM_RDATA_I), .W_O(W_O),
    .STATUS_O(STATUS_O), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I));

// ### subtract_w_execution_tb_top.sv
`timescale 1ns/1ps
module subtract_w_execution_tb_top;
    logic clk = 1'b0; // 250 MHz core clock
    logic arst_n = 1'b0;
    logic valid = 1'b0;
    logic [15:0] word = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic ready;
    logic done;
    swx_pkg::swx_mem_req_t mem;
    logic [7:0] rdata;
    swx_pkg::swx_apb_rsp_t apb_rsp;
    logic [7:0] w;
    logic [4:0] st;
    logic [31:0] rd; // last read data
    logic err; // last slave error
    int n_errors = 0;
    int compares = 0;
    // operand table: three borrow cases, overflow, nibble borrow, three file forms
    logic [15:0] ops [8] = '{16'h0802, 16'h0802, 16'h0802, 16'h0880, 16'h0810,
                             16'h5F45, 16'h5C20, 16'h5E90};
    logic [7:0] wv [8] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h02, 8'h02, 8'hFF};
    logic [7:0] fv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h7F};
    always #2 clk = ~clk;
    swx_core dut (.CLK_I(clk), .ARST_N_I(arst_n), .INSTR_VALID_I(valid), .INSTR_WORD_I(word),
        .INSTR_READY_O(ready), .INSTR_DONE_O(done), .MEM_O(mem), .MEM_RDATA_I(rdata),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .APB_O(apb_rsp), .W_O(w), .STATUS_O(st));
    swx_mem_model u_mem (.clk_i(clk), .arst_n_i(arst_n), .req_i(mem), .rdata_o(rdata));
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (apb_rsp.pready !== 1'b1 && i < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            n_errors++;
            report_and_stop;
        end
    endtask
    // offer a word until decode takes it, then wait for done if one is due
    task exec(input logic [15:0] iw, input bit want_done);
        int i;
        @(posedge clk);
        valid <= 1'b1;
        word <= iw;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ready !== 1'b1 && i < 20);
        valid <= 1'b0;
        if (want_done && i < 20) begin
            i = 0;
            do begin
                @(posedge clk);
                i++;
            end while (done !== 1'b1 && i < 20);
        end
        if (i >= 20) begin
            n_errors++;
            report_and_stop;
        end
    endtask
    // expected flags {n, ov, z, dc, c} of a minus b
    function automatic logic [4:0] flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {d[7], (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic file;
        logic [7:0] opnd;
        logic [7:0] diff;
        logic [11:0] addr;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        apb_xfer(1'b0, swx_pkg::SWX_OFS_BSR, 32'h0);
        cmp("bank reset", 32'h0, rd);
        apb_xfer(1'b1, swx_pkg::SWX_OFS_BSR, 32'h3);
        for (int n = 0; n < 8; n++) begin
            file = ops[n][15:10] == 6'h17;
            opnd = file ? fv[n] : ops[n][7:0];
            addr = ops[n][8] ? {4'h3, ops[n][7:0]} : {ops[n][7] ? 4'hF : 4'h0, ops[n][7:0]};
            diff = opnd - wv[n];
            if (file) u_mem.m[addr] = fv[n];
            apb_xfer(1'b1, swx_pkg::SWX_OFS_W, {24'h0, wv[n]});
            exec(ops[n], 1'b1);
            cmp("status", flags(opnd, wv[n]), st);
            cmp("w", (file && ops[n][9]) ? wv[n] : diff, w);
            if (file) cmp("file", ops[n][9] ? diff : fv[n], u_mem.m[addr]);
        end
        exec(16'hFFFF, 1'b0);
        apb_xfer(1'b0, swx_pkg::SWX_OFS_EXEC, 32'h0);
        cmp("unknown opcode flag", 32'h1, rd & 32'h1);
        cmp("w after refusal", {24'h0, wv[7]}, w);
        cmp("status after refusal", flags(fv[7], wv[7]), st);
        apb_xfer(1'b0, swx_pkg::SWX_OFS_RESULT, 32'h0);
        cmp("last difference", 32'h80, rd);
        apb_xfer(1'b1, swx_pkg::SWX_OFS_EXEC, 32'h1);
        apb_xfer(1'b0, swx_pkg::SWX_OFS_EXEC, 32'h0);
        cmp("cleared opcode flag", 32'h0, rd);
        apb_xfer(1'b1, swx_pkg::SWX_OFS_STATUS, 32'h15);
        apb_xfer(1'b0, swx_pkg::SWX_OFS_STATUS, 32'h0);
        cmp("status write", 32'h15, rd);
        apb_xfer(1'b0, 8'h20, 32'h0);
        cmp("unmapped error", 32'h1, err);
        cmp("unmapped data", 32'h0, rd);
        // mid-run reset must bring back the reset values
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        cmp("w after reset", 32'h0, w);
        cmp("status after reset", 32'h0, st);
        apb_xfer(1'b0, swx_pkg::SWX_OFS_BSR, 32'h0);
        cmp("bank after reset", 32'h0, rd);
        exec(16'h0802, 1'b1);
        cmp("w after restart", 32'h2, w);
        cmp("status after restart", flags(8'h02, 8'h00), st);
        report_and_stop;
    end
endmodule
